/* hdl/partner_page_pkg.sv */
/*
  Package for the link partner next page status word: register offsets,
  field positions, reset values and the packed carriers.
  Assumes a 32-bit APB slave with one register per aligned word.
*/
package partner_page_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] PARTNER_PAGE_IDX = 8'h05;
  localparam logic [11:0] PARTNER_PAGE_ADDR = {2'h0, PARTNER_PAGE_IDX, 2'h0};
  localparam logic [11:0] PAGE_MODE_ADDR = 12'h040;
  localparam int MODE_BIT = 0;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int MORE_PAGES_BIT = 15;
  localparam int ACK_BIT = 14;
  localparam int MSG_PAGE_BIT = 13;
  localparam int COMPLY_BIT = 12;
  localparam int TOGGLE_BIT = 11;
  localparam int CODE_MSB = 10;
  localparam int CODE_LSB = 0;
  localparam int CODE_W = 11;

  localparam logic [15:0] PAGE_WORD_RESET = 16'h0000;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic more_pages_flag;
    logic ack;
    logic message_page_flag;
    logic comply_ability_flag;
    logic toggle;
    logic [CODE_W-1:0] code;
  } page_word_s;

  typedef struct packed {
    logic valid;
    page_word_s word;
  } page_update_s;

endpackage

/* hdl/partner_page_reg.sv */
/*
  Link partner next page status word behind an APB slave.
  Assumes the negotiation engine presents each received page as a one-cycle
  pulse on the same clock, and a level telling whether next pages run.
*/
`timescale 1ns/1ps
module partner_page_reg
  import partner_page_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire page_update_s PAGE_RX,
  input wire logic NEXT_PAGE_MODE,
  input wire logic [15:0] BASE_PAGE_WORD
);

  // ----------------------------------------------------------------------
  // Received next page word
  // ----------------------------------------------------------------------
  page_word_s word_q;
  logic mode_q;

  // Only the engine's pulse loads the word; the bus has no path here
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      word_q <= PAGE_WORD_RESET;
    end else if (PAGE_RX.valid) begin
      word_q <= PAGE_RX.word;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      mode_q <= 1'h0;
    end else begin
      mode_q <= NEXT_PAGE_MODE;
    end
  end

  // ----------------------------------------------------------------------
  // APB slave: zero wait states, unmapped reads return zero with error
  // ----------------------------------------------------------------------
  logic access;
  logic [31:0] rdata_d;
  logic err_d;

  assign access = PSEL && PENABLE;
  assign PREADY = 1'h1;

  always_comb begin
    rdata_d = RDATA_ZERO;
    err_d = 1'h0;
    if (PADDR == PARTNER_PAGE_ADDR) begin
      // Next page view replaces base view while pages run
      rdata_d[$bits(page_word_s)-1:0] =
        mode_q ? word_q : BASE_PAGE_WORD;
    end else if (PADDR == PAGE_MODE_ADDR) begin
      rdata_d[MODE_BIT] = mode_q;
    end else begin
      err_d = 1'h1;
    end
  end

  // Read data is registered in setup so it is stable in access
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      PRDATA <= RDATA_ZERO;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= rdata_d;
    end
  end

  // Writes to mapped words are accepted and dropped
  assign PSLVERR = access && err_d;

  // ----------------------------------------------------------------------
  // Checks: bus phases shared by the properties below
  // ----------------------------------------------------------------------
  // Write access not masked by a page arriving in the same cycle
  sequence wr_access_s;
    PSEL && PENABLE && PWRITE && !PAGE_RX.valid;
  endsequence

  // Any write phase, setup or access
  sequence wr_phase_s;
    PSEL && PWRITE;
  endsequence

  // Read setup of the partner word, next page view selected
  sequence page_rd_setup_s;
    PSEL && !PENABLE && !PWRITE && mode_q && PADDR == PARTNER_PAGE_ADDR;
  endsequence

  // Same setup with no fresh page racing the read
  sequence quiet_rd_setup_s;
    PSEL && !PENABLE && !PWRITE && mode_q && PADDR == PARTNER_PAGE_ADDR &&
      !PAGE_RX.valid;
  endsequence

  // Read setup of the partner word, base view selected
  sequence base_rd_setup_s;
    PSEL && !PENABLE && !PWRITE && !mode_q && PADDR == PARTNER_PAGE_ADDR;
  endsequence

  // Read setup of the mode status word
  sequence mode_rd_setup_s;
    PSEL && !PENABLE && !PWRITE && PADDR == PAGE_MODE_ADDR;
  endsequence

  // Any phase aimed at an address that is not decoded
  sequence unmapped_s;
    PSEL && PADDR != PARTNER_PAGE_ADDR && PADDR != PAGE_MODE_ADDR;
  endsequence

  // Fresh page, then a read of it on the very next edge
  sequence page_then_read_s;
    PAGE_RX.valid ##1 quiet_rd_setup_s;
  endsequence

  // ----------------------------------------------------------------------
  // Checks: stored page word
  // ----------------------------------------------------------------------
  word_loads_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    PAGE_RX.valid |=> word_q == $past(PAGE_RX.word))
    else $error("page word not loaded");

  word_holds_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    wr_access_s |=> $stable(word_q))
    else $error("bus write changed page word");

  // Only the engine may move the word
  word_still_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    !PAGE_RX.valid |=> $stable(word_q))
    else $error("page word moved without a page");

  reset_zero_a: assert property (
    @(posedge CORE_CLK)
    !RESET_N |=> word_q == PAGE_WORD_RESET && PRDATA == RDATA_ZERO)
    else $error("reset value not zero");

  // ----------------------------------------------------------------------
  // Checks: next page view fields
  // ----------------------------------------------------------------------
  // Worst case: page and read setup on adjacent edges
  ack_bit_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    page_then_read_s |=>
      PRDATA[ACK_BIT] == $past(PAGE_RX.word.ack, 2))
    else $error("ack bit wrong");

  msg_bit_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    page_rd_setup_s |=>
      PRDATA[MSG_PAGE_BIT] == $past(word_q.message_page_flag))
    else $error("message page bit wrong");

  comply_bit_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    page_rd_setup_s |=>
      PRDATA[COMPLY_BIT] == $past(word_q.comply_ability_flag))
    else $error("comply bit wrong");

  toggle_bit_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    page_rd_setup_s |=>
      PRDATA[TOGGLE_BIT] == $past(word_q.toggle))
    else $error("toggle bit wrong");

  more_bit_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    page_rd_setup_s |=>
      PRDATA[MORE_PAGES_BIT] == $past(word_q.more_pages_flag))
    else $error("more pages bit wrong");

  code_field_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    page_rd_setup_s |=>
      PRDATA[CODE_MSB:CODE_LSB] == $past(word_q.code) &&
      (PRDATA >> $bits(page_word_s)) == RDATA_ZERO)
    else $error("code field wrong");

  // ----------------------------------------------------------------------
  // Checks: views and bus responses
  // ----------------------------------------------------------------------
  base_view_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    base_rd_setup_s |=>
      PRDATA[$bits(page_word_s)-1:0] == $past(BASE_PAGE_WORD))
    else $error("base view not shown");

  mode_view_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    mode_rd_setup_s |=>
      PRDATA[MODE_BIT] == $past(mode_q) &&
      (PRDATA >> (MODE_BIT + 1)) == RDATA_ZERO)
    else $error("mode word wrong");

  // Error only in the access phase, never in setup
  unmapped_err_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    unmapped_s |-> PSLVERR == PENABLE)
    else $error("unmapped access error wrong");

  mapped_no_err_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (PSEL && (PADDR == PARTNER_PAGE_ADDR || PADDR == PAGE_MODE_ADDR))
      |-> !PSLVERR)
    else $error("error on mapped address");

  unmapped_zero_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (unmapped_s ##0 (!PENABLE && !PWRITE)) |=> PRDATA == RDATA_ZERO)
    else $error("unmapped read not zero");

  // Writes never disturb the last read data
  write_no_read_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    wr_phase_s |=> $stable(PRDATA))
    else $error("write changed read data");

endmodule

/* tb/page_source.sv */
/* Model of the negotiation engine feeding received pages.
   Assumes the bench raises send for one cycle per page. */
`timescale 1ns/1ps
module page_source
  import partner_page_pkg::*;
(
  input wire logic clk,
  input wire logic send,
  input wire page_word_s word,
  output page_update_s rx
);
  // Between pages the word wanders so stale data cannot pass
  always_ff @(posedge clk) begin
    rx.valid <= send;
    rx.word <= send ? word : ~rx.word;
  end
endmodule

/* tb/tb_autoneg_partner_next_page_status.sv */
/* Self-checking bench for the next page status word.
   Assumes zero or more APB wait states and the page source model. */
`timescale 1ns/1ps
module tb_autoneg_partner_next_page_status;
  import partner_page_pkg::*;
  logic CORE_CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic NEXT_PAGE_MODE = 0, send = 0, PREADY, PSLVERR, err;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, rd, mdl, seed = 32'h0000_0056;
  logic [3:0] PSTRB = '0;
  logic [15:0] BASE_PAGE_WORD = '0, word = '0;
  page_update_s PAGE_RX;
  int n_mismatch = 0, comparisons = 0, i;
  partner_page_reg uut (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PAGE_RX(PAGE_RX), .NEXT_PAGE_MODE(NEXT_PAGE_MODE),
    .BASE_PAGE_WORD(BASE_PAGE_WORD));
  page_source src (.clk(CORE_CLK), .send(send), .word(word), .rx(PAGE_RX));
  initial begin
    forever #2 CORE_CLK = ~CORE_CLK;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task end_sim;
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // --------------------------------------------------------------
  // APB cycle; one idle edge after so no signal is set twice
  // --------------------------------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= 4'hf;
    @(posedge CORE_CLK);
    PENABLE <= 1'h1;
    k = 0;
    do begin
      @(posedge CORE_CLK);
      k++;
    end while (PREADY !== 1'h1 && k < 50);
    if (k >= 50) begin
      n_mismatch++;
      end_sim;
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge CORE_CLK);
  endtask
  // Returns on the edge that loads the word, so a read can follow at once
  task page(input logic [15:0] w);
    send <= 1'h1;
    word <= w;
    @(posedge CORE_CLK);
    send <= 1'h0;
    @(posedge CORE_CLK);
  endtask
  initial begin
    repeat (6) @(posedge CORE_CLK);
    mdl = rnd();
    BASE_PAGE_WORD <= mdl[15:0];
    NEXT_PAGE_MODE <= 1'h1;
    RESET_N <= 1'h1;
    @(posedge CORE_CLK);
    apb(1'h0, PARTNER_PAGE_ADDR, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0000_0000, err}, 32'h0);
    for (i = 0; i < 24; i++) begin
      mdl = rnd() & 32'h0000_ffff;
      page(mdl[15:0]);
      if (i % 3 == 0) apb(1'h1, PARTNER_PAGE_ADDR, ~mdl);
      apb(1'h0, PARTNER_PAGE_ADDR, 32'h0);
      chk(rd, mdl);
      chk({31'h0000_0000, err}, 32'h0);
    end
    apb(1'h0, PAGE_MODE_ADDR, 32'h0);
    chk(rd, 32'h1);
    NEXT_PAGE_MODE <= 1'h0;
    @(posedge CORE_CLK);
    apb(1'h0, PARTNER_PAGE_ADDR, 32'h0);
    chk(rd, {16'h0000, BASE_PAGE_WORD});
    apb(1'h0, PAGE_MODE_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 12'h100, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0000_0000, err}, 32'h1);
    NEXT_PAGE_MODE <= 1'h1;
    RESET_N <= 1'h0;
    repeat (2) @(posedge CORE_CLK);
    RESET_N <= 1'h1;
    repeat (2) @(posedge CORE_CLK);
    apb(1'h0, PARTNER_PAGE_ADDR, 32'h0);
    chk(rd, 32'h0);
    end_sim;
  end
endmodule
